// File: logic/mfet_pkg.sv
// Package for the multifunction event timer: register offsets, fields, reset values, clock taps.
// Assumes a nibble-wide register port clocked by mclk, and an instruction-cycle enable from outside.
package mfet_pkg;
  localparam logic [9:0] OFS_MODE_ONE = 10'h009;
  localparam logic [9:0] OFS_RELOAD_LOW = 10'h00A;
  localparam logic [9:0] OFS_RELOAD_HIGH = 10'h00B;
  localparam logic [9:0] OFS_FLAGS = 10'h021;
  localparam logic [9:0] OFS_PIN_FUNC = 10'h024;
  localparam logic [9:0] OFS_MODE_TWO = 10'h026;
  localparam int FLAG_DONE_BIT = 0;
  localparam int FLAG_OVERRUN_BIT = 1;
  localparam int FUNC_SEL_BIT = 3;
  localparam int PIN_EN_LOW_BIT = 0;
  localparam int PIN_EN_HIGH_BIT = 2;
  localparam logic [3:0] MODE_ONE_RESET = 4'h0;
  localparam logic [3:0] MODE_TWO_RESET = 4'h0;
  localparam logic [3:0] PIN_FUNC_RESET = 4'h0;
  localparam logic [3:0] RELOAD_LOW_RESET = 4'h0;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [2:0] CLK_SEL_EVENT = 3'h7;
  localparam int PRESCALER_WIDTH = 11;
  // Tap bit of the prescaler that falls once per selected period
  localparam int TAP_2048 = 10;
  localparam int TAP_512 = 8;
  localparam int TAP_128 = 6;
  localparam int TAP_32 = 4;
  localparam int TAP_8 = 2;
  localparam int TAP_4 = 1;
  localparam int TAP_2 = 0;

  typedef struct packed {
    logic func_sel;
    logic [2:0] clk_sel;
  } mfet_mode_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [9:0] addr;
    logic [3:0] wdata;
  } mfet_req_t;
endpackage

// File: logic/mfet_timer.sv
// Multifunction 8-bit event timer with reload and input capture, nibble register port.
// Assumes cyc_en pulses once per instruction cycle and the event pin is synchronous to mclk.
// Notes on behaviour
// - 8-bit counter: free-running, event counter, reload timer, input capture.
// - Clock select codes 0-6 pick prescaler periods 2048,512,128,32,8,4,2 cycles.
// - Clock select 7 counts edges of the event input pin.
// - Overflow of the counter raises an interrupt request.
// - Function select bit: 0 free-running at reset, 1 reload.
// - Mode register one: 4-bit write-only, cleared at reset and stop.
// - An event pin edge captures the counter value.
// - Each capture event raises an interrupt request.
// - Capture flags set by writing one; writing zero leaves them.
// - Capture flags are single bits at the flag address, reset to zero.
// - Event pin is input only, clocking the counter and triggering capture.
`timescale 1ns/1ps
module mfet_timer
  import mfet_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic stop_mode,
  input wire logic cyc_en,
  input wire mfet_pkg::mfet_req_t req,
  output logic [3:0] rdata,
  input wire logic event_input_pin,
  output logic overflow_irq,
  output logic capture_irq
);
  import mfet_pkg::*;

  logic [1:0] rst_sync_q;
  logic rst_n_i;
  mfet_mode_t timer_mode_one_q;
  logic [3:0] timer_mode_two_q;
  logic [3:0] pin_function_select_q;
  logic [3:0] reload_value_low_q;
  logic [3:0] reload_value_high_q;
  logic [3:0] reload_live_low_q;
  logic [7:0] reload_value;
  logic [7:0] event_timer_counter_q;
  logic [7:0] snapshot_q;
  logic capture_done_flag_q;
  logic capture_overrun_flag_q;
  logic [PRESCALER_WIDTH-1:0] presc_q;
  logic event_pin_q;
  logic event_edge;
  logic pin_enabled;
  logic tick;
  logic tap_tick;
  logic overflow;
  logic capture_mode;
  logic wr_mode_one;
  logic wr_low;
  logic wr_high;
  logic wr_flags;

  function automatic logic hit(input mfet_req_t r, input logic [9:0] ofs);
    hit = r.wr && (r.addr == ofs);
  endfunction

  // Reset leaves through two flops so every register is released on the same edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n_i = rst_sync_q[1];

  // Writes are taken on any clock with wr high; there is no wait state
  assign wr_mode_one = hit(req, OFS_MODE_ONE);
  assign wr_low = hit(req, OFS_RELOAD_LOW);
  assign wr_high = hit(req, OFS_RELOAD_HIGH);
  assign wr_flags = hit(req, OFS_FLAGS);

  // Write-only, cleared by stop as well as reset
  always_ff @(posedge mclk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timer_mode_one_q <= MODE_ONE_RESET;
    end else if (stop_mode) begin
      timer_mode_one_q <= MODE_ONE_RESET;
    end else if (wr_mode_one) begin
      timer_mode_one_q <= req.wdata;
    end
  end

  // Second mode register is kept; this block uses it only as the capture enable, set by any nonzero value
  always_ff @(posedge mclk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timer_mode_two_q <= MODE_TWO_RESET;
      pin_function_select_q <= PIN_FUNC_RESET;
    end else begin
      if (hit(req, OFS_MODE_TWO)) begin
        timer_mode_two_q <= req.wdata;
      end
      if (hit(req, OFS_PIN_FUNC)) begin
        pin_function_select_q <= req.wdata;
      end
    end
  end
  // Capture function enabled by any nonzero value in mode register two
  assign capture_mode = |timer_mode_two_q;
  assign pin_enabled = pin_function_select_q[PIN_EN_LOW_BIT]
    | pin_function_select_q[PIN_EN_HIGH_BIT];

  // Reload value takes effect when the high nibble is written, so both halves load together
  always_ff @(posedge mclk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reload_value_low_q <= RELOAD_LOW_RESET;
      reload_value_high_q <= 4'h0;
      reload_live_low_q <= RELOAD_LOW_RESET;
    end else begin
      if (wr_low) begin
        reload_value_low_q <= req.wdata;
      end
      if (wr_high) begin
        reload_value_high_q <= req.wdata;
        reload_live_low_q <= reload_value_low_q;
      end
    end
  end
  // A low write alone never reaches the counter, so a half-written value is never loaded
  assign reload_value = {reload_value_high_q, reload_live_low_q};

  // The prescaler runs free; stop and mode writes leave its phase alone
  always_ff @(posedge mclk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      presc_q <= '0;
      event_pin_q <= 1'b1;
    end else begin
      if (cyc_en) begin
        presc_q <= presc_q + 1'b1;
      end
      event_pin_q <= event_input_pin;
    end
  end
  // Falling edge taken as the active event edge
  // History starts at the idle high level so reset never looks like an edge
  assign event_edge = event_pin_q & ~event_input_pin & pin_enabled;

  // A tap ticks when its bit rolls over, giving one pulse per selected period
  always_comb begin
    logic [PRESCALER_WIDTH-1:0] nxt;
    nxt = presc_q + 1'b1;
    case (timer_mode_one_q.clk_sel)
      3'h0: tap_tick = presc_q[TAP_2048] & ~nxt[TAP_2048];
      3'h1: tap_tick = presc_q[TAP_512] & ~nxt[TAP_512];
      3'h2: tap_tick = presc_q[TAP_128] & ~nxt[TAP_128];
      3'h3: tap_tick = presc_q[TAP_32] & ~nxt[TAP_32];
      3'h4: tap_tick = presc_q[TAP_8] & ~nxt[TAP_8];
      3'h5: tap_tick = presc_q[TAP_4] & ~nxt[TAP_4];
      3'h6: tap_tick = presc_q[TAP_2] & ~nxt[TAP_2];
      default: tap_tick = 1'b0;
    endcase
  end
  // The event clock ignores cyc_en: the pin is sampled on every mclk
  assign tick = (timer_mode_one_q.clk_sel == CLK_SEL_EVENT) ? event_edge
    : (tap_tick & cyc_en);
  // No overflow interrupt while stop holds the counter clear
  assign overflow = tick && !stop_mode && (event_timer_counter_q == 8'hFF);

  always_ff @(posedge mclk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      event_timer_counter_q <= COUNT_RESET;
    end else if (stop_mode) begin
      event_timer_counter_q <= COUNT_RESET;
    end else if (overflow) begin
      event_timer_counter_q <= timer_mode_one_q.func_sel ? reload_value : COUNT_RESET;
    end else if (tick) begin
      event_timer_counter_q <= event_timer_counter_q + 8'h01;
    end
  end

  // Capture uses the event edge; event counting and capture share the pin
  // Software can only set the flags; reset is the one way to clear them
  always_ff @(posedge mclk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      snapshot_q <= COUNT_RESET;
      capture_done_flag_q <= 1'b0;
      capture_overrun_flag_q <= 1'b0;
    end else begin
      if (capture_mode && event_edge) begin
        snapshot_q <= event_timer_counter_q;
      end
      if ((capture_mode && event_edge && !capture_done_flag_q) ||
          (wr_flags && req.wdata[FLAG_DONE_BIT])) begin
        capture_done_flag_q <= 1'b1;
      end
      if ((capture_mode && event_edge && capture_done_flag_q) ||
          (wr_flags && req.wdata[FLAG_OVERRUN_BIT])) begin
        capture_overrun_flag_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      overflow_irq <= 1'b0;
      capture_irq <= 1'b0;
    end else begin
      overflow_irq <= overflow;
      capture_irq <= capture_mode && event_edge;
    end
  end

  // Snapshot nibbles share the reload addresses: writes load, reads return the snapshot
  always_comb begin
    rdata = 4'h0;
    if (req.rd) begin
      case (req.addr)
        OFS_RELOAD_LOW: rdata = snapshot_q[3:0];
        OFS_RELOAD_HIGH: rdata = snapshot_q[7:4];
        OFS_FLAGS: rdata = {2'h0, capture_overrun_flag_q, capture_done_flag_q};
        default: rdata = 4'h0;
      endcase
    end
  end
endmodule

// File: test/mfet_timer_monitor.sv
// Checker for the event timer: interrupt pulses, capture cause and flag reads.
// Assumes it is bound to mfet_timer and sees only that module's ports.
`timescale 1ns/1ps
module mfet_timer_monitor
  import mfet_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic stop_mode,
  input wire mfet_pkg::mfet_req_t req,
  input wire logic [3:0] rdata,
  input wire logic event_input_pin,
  input wire logic overflow_irq,
  input wire logic capture_irq
);
  import mfet_pkg::*;
  logic pin_q;
  logic [2:0] since_q;
  logic [1:0] ncap_q;
  logic [1:0] wset_q;
  wire fr = req.rd && req.addr == OFS_FLAGS;
  wire wo = req.rd && req.addr inside {OFS_MODE_ONE, OFS_MODE_TWO, OFS_PIN_FUNC};
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_q <= 1'b1;
    end else begin
      pin_q <= event_input_pin;
    end
  end
  // Cycles since the last falling event edge, parked at 7
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      since_q <= 3'h7;
    end else if (pin_q && !event_input_pin) begin
      since_q <= 3'h0;
    end else if (since_q != 3'h7) begin
      since_q <= since_q + 3'h1;
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ncap_q <= 2'h0;
    end else if (capture_irq && ncap_q != 2'h3) begin
      ncap_q <= ncap_q + 2'h1;
    end
  end
  // Flags that software has set by writing ones since reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wset_q <= 2'h0;
    end else if (req.wr && req.addr == OFS_FLAGS) begin
      wset_q <= wset_q | req.wdata[1:0];
    end
  end
  chk_ovf_pulse: assert property (overflow_irq |=> !overflow_irq)
    else $error("overflow pulse too long");
  chk_cap_pulse: assert property (capture_irq |=> !capture_irq)
    else $error("capture pulse too long");
  chk_wo_regs: assert property (wo |-> rdata == 4'h0)
    else $error("write-only register read back");
  chk_stop_quiet: assert property (stop_mode |=> !overflow_irq)
    else $error("overflow during stop");
  chk_cap_cause: assert property (capture_irq |-> since_q <= 3'h4)
    else $error("capture without event edge");
  chk_flags_zero: assert property (fr && ncap_q == 2'h0 |-> (rdata[1:0] & ~wset_q) == 2'h0)
    else $error("flag set without capture");
  chk_wset_flags: assert property (fr |-> (rdata[1:0] & wset_q) == wset_q)
    else $error("flag written one reads zero");
  chk_done_set: assert property (fr && ncap_q != 2'h0 |-> rdata[FLAG_DONE_BIT])
    else $error("done flag missing");
  chk_overrun_set: assert property (fr && ncap_q >= 2'h2 |-> rdata[FLAG_OVERRUN_BIT])
    else $error("overrun flag missing");
  cover property (overflow_irq);
  cover property (capture_irq);
  cover property (fr && ncap_q >= 2'h2);
endmodule
bind mfet_timer mfet_timer_monitor u_mon(.mclk(mclk), .rst_n(rst_n), .stop_mode(stop_mode),
  .req(req), .rdata(rdata), .event_input_pin(event_input_pin), .overflow_irq(overflow_irq),
  .capture_irq(capture_irq));

// File: test/mfet_event_src.sv
// Event source model: pulls the event pin low for three clocks per request.
// Assumes fire is a one-clock request from the bench, taken on mclk.
`timescale 1ns/1ps
module mfet_event_src (
  input wire logic mclk,
  input wire logic fire,
  output logic event_input_pin
);
  logic [1:0] low_q = 2'h0;
  // Long low and high phases keep every edge visible to a synchronous sampler
  always_ff @(posedge mclk) begin
    if (fire) begin
      low_q <= 2'h3;
    end else if (low_q != 2'h0) begin
      low_q <= low_q - 2'h1;
    end
  end
  assign event_input_pin = (low_q == 2'h0);
endmodule

// File: test/mfet_timer_tb.sv
// Bench for the event timer: registers, event counting, reload, capture, clock taps.
// Assumes cyc_en may be held high so every clock is an instruction cycle.
`timescale 1ns/1ps
module mfet_timer_tb;
  import mfet_pkg::*;
  logic mclk = 0, rst_n = 0, stop_mode = 0, cyc_en = 1, fire = 0;
  mfet_req_t req = '0;
  logic [3:0] rdata;
  logic event_input_pin, overflow_irq, capture_irq;
  logic [7:0] expq[$];
  logic [31:0] lfsr_q = 32'h0EE3;
  logic [7:0] rl;
  int per[7] = '{2048, 512, 128, 32, 8, 4, 2};
  int err_total = 0, num_checks = 0;
  mfet_timer dut(.mclk(mclk), .rst_n(rst_n), .stop_mode(stop_mode), .cyc_en(cyc_en),
    .req(req), .rdata(rdata), .event_input_pin(event_input_pin),
    .overflow_irq(overflow_irq), .capture_irq(capture_irq));
  mfet_event_src src(.mclk(mclk), .fire(fire), .event_input_pin(event_input_pin));
  initial forever #5 mclk = ~mclk;
  function automatic logic [7:0] pop();
    return expq.size() ? expq.pop_front() : 8'hFF;
  endfunction
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic cmp_read(input logic [3:0] got);
    chk("read", pop(), {4'h1, got});
  endtask
  // The interrupt level goes into the compared word, so an unknown interrupt cannot pass
  task automatic cmp_irq(input string what, input logic [3:0] kind, input logic got);
    chk(what, pop(), {kind, 3'h0, got});
  endtask
  task automatic bus(input logic w, input logic [9:0] a, input logic [3:0] d);
    @(posedge mclk);
    req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge mclk);
    req <= '0;
  endtask
  task automatic rdchk(input logic [9:0] a, input logic [3:0] e);
    expq.push_back({4'h1, e});
    bus(1'b0, a, 4'h0);
  endtask
  task automatic ev(input int n);
    repeat (n) begin
      @(posedge mclk);
      fire <= 1'b1;
      @(posedge mclk);
      fire <= 1'b0;
      repeat (4) @(posedge mclk);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge mclk) begin
    if (req.rd) cmp_read(rdata);
    if (rst_n && overflow_irq !== 1'b0) cmp_irq("overflow", 4'h2, overflow_irq);
    if (rst_n && capture_irq !== 1'b0) cmp_irq("capture", 4'h3, capture_irq);
  end
  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    rdchk(OFS_FLAGS, 4'h0);
    rdchk(10'h3FF, 4'h0);
    rdchk(OFS_MODE_ONE, 4'h0);
    bus(1'b1, OFS_FLAGS, 4'h0);
    rdchk(OFS_FLAGS, 4'h0);
    $display("registers test done");
    lfsr_q = lfsr_next(lfsr_q);
    rl = lfsr_q[7:0];
    bus(1'b1, OFS_PIN_FUNC, 4'h4);
    bus(1'b1, OFS_RELOAD_LOW, rl[3:0]);
    bus(1'b1, OFS_RELOAD_HIGH, rl[7:4]);
    bus(1'b1, OFS_MODE_ONE, 4'hF);
    ev(255);
    expq.push_back(8'h21);
    ev(1);
    ev(255 - int'(rl));
    expq.push_back(8'h21);
    ev(1);
    $display("reload test done");
    // Without cyc_en and off the event clock the count holds at the reload value
    cyc_en <= 1'b0;
    bus(1'b1, OFS_MODE_ONE, 4'h8);
    bus(1'b1, OFS_MODE_TWO, 4'h1);
    repeat (2) begin
      expq.push_back(8'h31);
      ev(1);
    end
    rdchk(OFS_RELOAD_LOW, rl[3:0]);
    rdchk(OFS_RELOAD_HIGH, rl[7:4]);
    rdchk(OFS_FLAGS, 4'h3);
    $display("capture test done");
    // Only a reset clears the flags; afterwards software may set each one
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    rdchk(OFS_FLAGS, 4'h0);
    bus(1'b1, OFS_FLAGS, 4'h1);
    rdchk(OFS_FLAGS, 4'h1);
    bus(1'b1, OFS_FLAGS, 4'h2);
    rdchk(OFS_FLAGS, 4'h3);
    $display("flag set test done");
    cyc_en <= 1'b1;
    // One overflow in 384 periods tells each of the taps for codes 2 to 6 apart from its neighbours
    for (int c = 2; c <= 6; c++) begin
      stop_mode <= 1'b1;
      repeat (3) @(posedge mclk);
      stop_mode <= 1'b0;
      bus(1'b1, OFS_MODE_ONE, 4'(c));
      expq.push_back(8'h21);
      repeat (384 * per[c]) @(posedge mclk);
    end
    chk("queue", 8'h00, 8'(expq.size()));
    $display("clock tap test done");
    test_done;
  end
  initial begin
    repeat (95000) @(posedge mclk);
    err_total++;
    test_done;
  end
endmodule
